// [logic/srp_pkg.sv]
package srp_pkg;

  localparam int unsigned SRP_DATA_W = 16;
  localparam int unsigned SRP_ADDR_W = 12;

  // word offsets on the host interface
  localparam logic [11:0] SRP_OFS_PROC_ONE  = 12'h000;
  localparam logic [11:0] SRP_OFS_PROC_TWO  = 12'h001;
  localparam logic [11:0] SRP_OFS_ERR_ONE   = 12'h002;
  localparam logic [11:0] SRP_OFS_RESERVED_WORD_THREE_THREE = 12'h003;

  localparam logic [15:0] SRP_RST_PROC_ONE = 16'h0000;
  localparam logic [15:0] SRP_RST_PROC_TWO = 16'h0000;
  localparam logic [15:0] SRP_RST_ERR_ONE  = 16'h0000;

  // implemented bits; everything else reads zero and ignores writes
  localparam logic [15:0] SRP_MASK_PROC_ONE = 16'h5EDF;
  localparam logic [15:0] SRP_MASK_PROC_TWO = 16'h6000;
  localparam logic [15:0] SRP_MASK_ERR_ONE  = 16'h077F;

  // processing_control_one fields
  localparam int unsigned SRP_B_TIMING_REF_REMAP_OFF      = 14;
  localparam int unsigned SRP_B_EDH_FLAG_FREEZE           = 12;
  localparam int unsigned SRP_B_EDH_CHECKWORD_INSERT_OFF  = 11;
  localparam int unsigned SRP_B_BLANK_SELECT              = 10;
  localparam int unsigned SRP_B_ANCILLARY_EXTRACT_OFF     = 9;
  localparam int unsigned SRP_B_TIMING_FORMAT_PIN_OVERRIDE = 7;
  localparam int unsigned SRP_B_TIMING_FORMAT             = 6;
  localparam int unsigned SRP_B_ILLEGAL_CODE_REMAP_OFF    = 4;
  localparam int unsigned SRP_B_ANCILLARY_SUM_INSERT_OFF  = 3;
  localparam int unsigned SRP_B_LINE_CHECKWORD_INSERT_OFF = 2;
  localparam int unsigned SRP_B_LINE_NUMBER_INSERT_OFF    = 1;
  localparam int unsigned SRP_B_TIMING_REF_INSERT_OFF     = 0;

  // processing_control_two fields
  localparam int unsigned SRP_B_ASI_POLARITY_FORCE          = 14;
  localparam int unsigned SRP_B_ASI_POLARITY_AUTODETECT_OFF = 13;

  // error_status_one fields
  localparam int unsigned SRP_B_VIDEO_STANDARD_ERROR      = 10;
  localparam int unsigned SRP_B_FULL_FIELD_CHECKWORD_ERR  = 9;
  localparam int unsigned SRP_B_ACTIVE_PICTURE_CHECKWORD_ERR = 8;
  localparam int unsigned SRP_B_CHROMA_ANCILLARY_SUM_ERR  = 6;
  localparam int unsigned SRP_B_LUMA_ANCILLARY_SUM_ERR    = 5;
  localparam int unsigned SRP_B_CHROMA_LINE_CHECKWORD_ERR = 4;
  localparam int unsigned SRP_B_LUMA_LINE_CHECKWORD_ERR   = 3;
  localparam int unsigned SRP_B_LINE_NUMBER_ERR           = 2;
  localparam int unsigned SRP_B_START_ACTIVE_VIDEO_ERR    = 1;
  localparam int unsigned SRP_B_END_ACTIVE_VIDEO_ERR      = 0;

  typedef struct packed {
    logic              wr;
    logic              rd;
    logic [11:0]       addr;
    logic [15:0]       wdata;
  } srp_host_req_s;

  // one-cycle event pulses from the video checkers
  typedef struct packed {
    logic video_standard_error;
    logic full_field_checkword_error;
    logic active_picture_checkword_error;
    logic chroma_ancillary_sum_error;
    logic luma_ancillary_sum_error;
    logic chroma_line_checkword_error;
    logic luma_line_checkword_error;
    logic line_number_error;
    logic start_active_video_error;
    logic end_active_video_error;
  } srp_err_s;

  typedef struct packed {
    logic line_blank;
    logic trs_h_bit;
    logic cea_hsync;
  } srp_timing_s;

  typedef struct packed {
    logic timing_ref_remap_off;
    logic edh_flag_freeze;
    logic edh_checkword_insert_off;
    logic ancillary_extract_off;
    logic illegal_code_remap_off;
    logic ancillary_sum_insert_off;
    logic line_checkword_insert_off;
    logic line_number_insert_off;
    logic timing_ref_insert_off;
    logic timing_format_cea;
  } srp_ctrl_s;

endpackage

// [logic/srp_regs.sv]
// Summary of operation
// - bit 14 stops TRS word remapping
// - bit 12 freezes EDH error flags
// - bit 11 stops EDH CRC correction, insertion
// - bit 10 low: H spans whole blanking
// - bit 10 high: H follows TRS H bit
// - blanking selection only when CEA timing off
// - bit 9 disables ancillary extraction FIFO
// - bit 7 replaces pin with register format bit
// - bit 6 selects FVH or CEA timing
// - bit 4 stops illegal code remapping
// - bit 3 stops ancillary checksum insertion
// - bit 2 stops HD line CRC insertion
// - bit 1 stops HD line number insertion
// - bit 0 stops TRS word insertion
// - ASI polarity autodetect unless bit 13 high
// - autodetect off: bit 14 forces polarity
// - status bit 10 flags video standard error
// - status bits 9, 8 flag EDH CRC errors
// - status bits 6, 5 flag ancillary checksum errors
// - status bits 4, 3 flag line CRC errors
// - status bit 2 flags line number error
// - status bits 1, 0 flag SAV, EAV errors
module srp_regs #(
  parameter int unsigned DATA_W = 16,
  parameter int unsigned ADDR_W = 12
) (
  input  wire logic                  ref_clk,
  input  wire logic                  sys_rst,
  input  wire srp_pkg::srp_host_req_s host_req,
  output logic [15:0]                host_rdata,
  output logic                       host_rvalid,
  input  wire logic                  timing_format_pin,
  input  wire srp_pkg::srp_timing_s  timing_in,
  input  wire logic                  asi_mode,
  input  wire logic                  asi_detected_inverted,
  input  wire srp_pkg::srp_err_s     err_in,
  output srp_pkg::srp_ctrl_s         ctrl,
  output logic                       h_blank,
  output logic                       asi_invert
);
  import srp_pkg::*;

  if (DATA_W != SRP_DATA_W || ADDR_W != SRP_ADDR_W) begin : g_bad_width
    $error("srp_regs: only 16-bit data and 12-bit addresses are supported");
  end

  logic [15:0] proc_one_r;
  logic [15:0] proc_one_nxt;
  logic [15:0] proc_two_r;
  logic [15:0] proc_two_nxt;
  logic [15:0] err_stat_r;
  logic [15:0] err_stat_nxt;
  logic [15:0] rdata_r;
  logic [15:0] rdata_nxt;
  logic        rvalid_r;
  logic        rvalid_nxt;
  srp_ctrl_s   ctrl_r;
  srp_ctrl_s   ctrl_nxt;
  logic        h_blank_r;
  logic        h_blank_nxt;
  logic        asi_invert_r;
  logic        asi_invert_nxt;
  logic [15:0] err_event;
  logic        wr_one;
  logic        wr_two;
  logic        wr_err;
  logic        format_cea;

  assign wr_one = host_req.wr && (host_req.addr == SRP_OFS_PROC_ONE);
  assign wr_two = host_req.wr && (host_req.addr == SRP_OFS_PROC_TWO);
  assign wr_err = host_req.wr && (host_req.addr == SRP_OFS_ERR_ONE);

  // configuration registers
  always_comb begin
    proc_one_nxt = proc_one_r;
    proc_two_nxt = proc_two_r;
    if (wr_one) begin
      proc_one_nxt = host_req.wdata & SRP_MASK_PROC_ONE;
    end
    if (wr_two) begin
      proc_two_nxt = host_req.wdata & SRP_MASK_PROC_TWO;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      proc_one_r <= SRP_RST_PROC_ONE;
      proc_two_r <= SRP_RST_PROC_TWO;
    end else begin
      proc_one_r <= proc_one_nxt;
      proc_two_r <= proc_two_nxt;
    end
  end

  // error events placed at their status positions
  always_comb begin
    err_event                                     = 16'h0000;
    err_event[SRP_B_VIDEO_STANDARD_ERROR]         = err_in.video_standard_error;
    err_event[SRP_B_FULL_FIELD_CHECKWORD_ERR]     = err_in.full_field_checkword_error;
    err_event[SRP_B_ACTIVE_PICTURE_CHECKWORD_ERR] =
      err_in.active_picture_checkword_error;
    err_event[SRP_B_CHROMA_ANCILLARY_SUM_ERR]     = err_in.chroma_ancillary_sum_error;
    err_event[SRP_B_LUMA_ANCILLARY_SUM_ERR]       = err_in.luma_ancillary_sum_error;
    err_event[SRP_B_CHROMA_LINE_CHECKWORD_ERR]    = err_in.chroma_line_checkword_error;
    err_event[SRP_B_LUMA_LINE_CHECKWORD_ERR]      = err_in.luma_line_checkword_error;
    err_event[SRP_B_LINE_NUMBER_ERR]              = err_in.line_number_error;
    err_event[SRP_B_START_ACTIVE_VIDEO_ERR]       = err_in.start_active_video_error;
    err_event[SRP_B_END_ACTIVE_VIDEO_ERR]         = err_in.end_active_video_error;
  end

  // a host write only ever clears; an event in the same cycle survives it
  for (genvar i = 0; i < 16; i++) begin : g_sticky
    if (SRP_MASK_ERR_ONE[i]) begin : g_live
      assign err_stat_nxt[i] = err_event[i] | (err_stat_r[i] & ~wr_err);
    end else begin : g_reserved_word_three
      assign err_stat_nxt[i] = 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      err_stat_r <= SRP_RST_ERR_ONE;
    end else begin
      err_stat_r <= err_stat_nxt;
    end
  end

  // read port: data one cycle after the strobe
  always_comb begin
    rvalid_nxt = host_req.rd;
    rdata_nxt  = 16'h0000;
    if (host_req.rd) begin
      case (host_req.addr)
        SRP_OFS_PROC_ONE: begin
          rdata_nxt = proc_one_r;
        end
        SRP_OFS_PROC_TWO: begin
          rdata_nxt = proc_two_r;
        end
        SRP_OFS_ERR_ONE: begin
          rdata_nxt = err_stat_r;
        end
        default: begin
          rdata_nxt = 16'h0000;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      rdata_r  <= 16'h0000;
      rvalid_r <= 1'b0;
    end else begin
      rdata_r  <= rdata_nxt;
      rvalid_r <= rvalid_nxt;
    end
  end

  // control outputs and timing selection
  assign format_cea = proc_one_r[SRP_B_TIMING_FORMAT_PIN_OVERRIDE]
                    ? proc_one_r[SRP_B_TIMING_FORMAT]
                    : timing_format_pin;

  always_comb begin
    ctrl_nxt.timing_ref_remap_off      = proc_one_r[SRP_B_TIMING_REF_REMAP_OFF];
    ctrl_nxt.edh_flag_freeze           = proc_one_r[SRP_B_EDH_FLAG_FREEZE];
    ctrl_nxt.edh_checkword_insert_off  = proc_one_r[SRP_B_EDH_CHECKWORD_INSERT_OFF];
    ctrl_nxt.ancillary_extract_off     = proc_one_r[SRP_B_ANCILLARY_EXTRACT_OFF];
    ctrl_nxt.illegal_code_remap_off    = proc_one_r[SRP_B_ILLEGAL_CODE_REMAP_OFF];
    ctrl_nxt.ancillary_sum_insert_off  = proc_one_r[SRP_B_ANCILLARY_SUM_INSERT_OFF];
    ctrl_nxt.line_checkword_insert_off = proc_one_r[SRP_B_LINE_CHECKWORD_INSERT_OFF];
    ctrl_nxt.line_number_insert_off    = proc_one_r[SRP_B_LINE_NUMBER_INSERT_OFF];
    ctrl_nxt.timing_ref_insert_off     = proc_one_r[SRP_B_TIMING_REF_INSERT_OFF];
    ctrl_nxt.timing_format_cea         = format_cea;
    // in CEA format the line carries the horizontal sync instead of blanking
    if (format_cea) begin
      h_blank_nxt = timing_in.cea_hsync;
    end else if (proc_one_r[SRP_B_BLANK_SELECT]) begin
      h_blank_nxt = timing_in.trs_h_bit;
    end else begin
      h_blank_nxt = timing_in.line_blank;
    end
    // polarity choice matters only to the ASI decoder
    if (!asi_mode) begin
      asi_invert_nxt = 1'b0;
    end else if (!proc_two_r[SRP_B_ASI_POLARITY_AUTODETECT_OFF]) begin
      asi_invert_nxt = asi_detected_inverted;
    end else begin
      asi_invert_nxt = ~proc_two_r[SRP_B_ASI_POLARITY_FORCE];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      ctrl_r       <= '0;
      h_blank_r    <= 1'b0;
      asi_invert_r <= 1'b0;
    end else begin
      ctrl_r       <= ctrl_nxt;
      h_blank_r    <= h_blank_nxt;
      asi_invert_r <= asi_invert_nxt;
    end
  end

  assign host_rdata  = rdata_r;
  assign host_rvalid = rvalid_r;
  assign ctrl        = ctrl_r;
  assign h_blank     = h_blank_r;
  assign asi_invert  = asi_invert_r;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);

  // a second write in the next cycle reaches ctrl one cycle after the value under test is sampled
  remap_ctrl_a: assert property (
    wr_one ##1 !wr_one |=>
      ctrl.timing_ref_remap_off == $past(host_req.wdata[SRP_B_TIMING_REF_REMAP_OFF], 2))
    else $error("remap control does not follow written bit 14");

  edh_freeze_a: assert property (
    wr_one && host_req.wdata[SRP_B_EDH_FLAG_FREEZE] ##1 !wr_one |=> ctrl.edh_flag_freeze)
    else $error("edh freeze not applied two cycles after write");

  blank_line_a: assert property (
    !format_cea && !proc_one_r[SRP_B_BLANK_SELECT] |=> h_blank == $past(timing_in.line_blank))
    else $error("h blank does not follow line blanking");

  blank_trs_a: assert property (
    !format_cea && proc_one_r[SRP_B_BLANK_SELECT] |=> h_blank == $past(timing_in.trs_h_bit))
    else $error("h blank does not follow trs h bit");

  cea_hsync_a: assert property (
    format_cea |=> h_blank == $past(timing_in.cea_hsync))
    else $error("cea format must ignore blanking selection");

  pin_override_a: assert property (
    !proc_one_r[SRP_B_TIMING_FORMAT_PIN_OVERRIDE] |=>
      ctrl.timing_format_cea == $past(timing_format_pin))
    else $error("timing format does not follow pin");

  asi_auto_a: assert property (
    asi_mode && !proc_two_r[SRP_B_ASI_POLARITY_AUTODETECT_OFF] |=>
      asi_invert == $past(asi_detected_inverted))
    else $error("asi polarity not auto detected");

  asi_force_a: assert property (
    asi_mode && proc_two_r[SRP_B_ASI_POLARITY_AUTODETECT_OFF] |=>
      asi_invert == !$past(proc_two_r[SRP_B_ASI_POLARITY_FORCE]))
    else $error("asi forced polarity wrong");

  std_err_set_a: assert property (
    err_in.video_standard_error |=> err_stat_r[SRP_B_VIDEO_STANDARD_ERROR])
    else $error("video standard error not recorded");

  sav_set_a: assert property (
    err_in.start_active_video_error |=> err_stat_r[SRP_B_START_ACTIVE_VIDEO_ERR])
    else $error("sav error not recorded, set must win over clear");

  sticky_hold_a: assert property (
    err_stat_r[SRP_B_LINE_NUMBER_ERR] && !wr_err |=> err_stat_r[SRP_B_LINE_NUMBER_ERR])
    else $error("line number error bit lost without a write");

  clear_a: assert property (
    wr_err && err_event == 16'h0000 |=> err_stat_r == 16'h0000)
    else $error("status write did not clear");

  read_reserved_word_three_a: assert property (
    host_req.rd && host_req.addr == SRP_OFS_RESERVED_WORD_THREE_THREE |=> host_rvalid && host_rdata == 16'h0000)
    else $error("reserved word must read zero");

  reserved_word_three_bits_a: assert property (
    (proc_one_r & ~SRP_MASK_PROC_ONE) == 16'h0000 && (err_stat_r & ~SRP_MASK_ERR_ONE) == 16'h0000)
    else $error("reserved bits not zero");

  insert_ctrl_a: assert property (
    {ctrl.edh_checkword_insert_off, ctrl.ancillary_extract_off, ctrl.illegal_code_remap_off,
     ctrl.ancillary_sum_insert_off, ctrl.line_checkword_insert_off,
     ctrl.line_number_insert_off, ctrl.timing_ref_insert_off} ==
      $past({proc_one_r[SRP_B_EDH_CHECKWORD_INSERT_OFF],
             proc_one_r[SRP_B_ANCILLARY_EXTRACT_OFF], proc_one_r[4:0]}))
    else $error("insert and extract controls do not follow register one");

  format_reg_a: assert property (
    proc_one_r[SRP_B_TIMING_FORMAT_PIN_OVERRIDE] |=>
      ctrl.timing_format_cea == $past(proc_one_r[SRP_B_TIMING_FORMAT]))
    else $error("timing format does not follow register bit");

  asi_off_a: assert property (
    !asi_mode |=> !asi_invert)
    else $error("asi polarity driven outside asi mode");

  reserved_word_three_two_a: assert property (
    (proc_two_r & ~SRP_MASK_PROC_TWO) == 16'h0000)
    else $error("reserved bits of register two not zero");

  // every live status bit must record its event on the next edge, clear or not
  for (genvar j = 0; j < 16; j++) begin : g_set_chk
    if (SRP_MASK_ERR_ONE[j]) begin : g_live
      event_set_a: assert property (
        @(posedge ref_clk) disable iff (sys_rst) err_event[j] |=> err_stat_r[j])
        else $error("status event not recorded");
    end
  end

  set_during_clear_c: cover property (wr_err && err_event != 16'h0000);
  cea_by_register_c:  cover property (proc_one_r[SRP_B_TIMING_FORMAT_PIN_OVERRIDE] && format_cea);
  asi_forced_c:       cover property (asi_mode && proc_two_r[SRP_B_ASI_POLARITY_AUTODETECT_OFF]);
  status_read_c:      cover property (host_req.rd && host_req.addr == SRP_OFS_ERR_ONE ##1
                                      host_rdata != 16'h0000);

endmodule // srp_regs

// [tb/srp_host_model.sv]
module srp_host_model
  import srp_pkg::*;
(
  input  wire logic          ref_clk,
  output srp_host_req_s      host_req,
  input  wire logic [15:0]   host_rdata,
  input  wire logic          host_rvalid
);
  timeunit 1ns;
  timeprecision 1ps;

  initial host_req = '0;

  // strobe and qualifiers held over exactly one taking edge, then address and
  // data are scrambled so that no stale value can pass for a held one
  task automatic write_word(input logic [11:0] a, input logic [15:0] d);
    @(negedge ref_clk);
    host_req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(negedge ref_clk);
    host_req = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
  endtask

  // answer lands on the taking edge itself and stands for one cycle,
  // so it is taken at the next falling edge, before the strobe drops
  task automatic read_word(input logic [11:0] a, output logic [15:0] d, output logic v);
    @(negedge ref_clk);
    host_req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'hA5A5};
    @(negedge ref_clk);
    d = host_rdata;
    v = host_rvalid;
    host_req = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: 16'h5A5A};
  endtask
endmodule // srp_host_model

// [tb/tb.sv]
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import srp_pkg::*;

  logic          ref_clk = 1'b0;
  logic          sys_rst = 1'b1;
  logic          timing_format_pin = 1'b0;
  logic          asi_mode = 1'b0;
  logic          asi_detected_inverted = 1'b0;
  srp_timing_s   timing_in = '0;
  srp_err_s      err_in = '0;
  srp_host_req_s host_req;
  srp_ctrl_s     ctrl;
  srp_ctrl_s     ec;
  logic [15:0]   host_rdata;
  logic          host_rvalid;
  logic          h_blank;
  logic          asi_invert;
  logic [15:0]   d;
  logic [15:0]   d2;
  logic [15:0]   acc;
  logic [15:0]   corner [4] = '{16'h0000, 16'h0400, 16'h04C0, 16'h0480};
  int            err_count = 0;
  int            checked = 0;
  int            seed = 77;
  int            cycles = 0;

  always #4 ref_clk = ~ref_clk;

  srp_regs uut (
    .ref_clk               (ref_clk),
    .sys_rst               (sys_rst),
    .host_req              (host_req),
    .host_rdata            (host_rdata),
    .host_rvalid           (host_rvalid),
    .timing_format_pin     (timing_format_pin),
    .timing_in             (timing_in),
    .asi_mode              (asi_mode),
    .asi_detected_inverted (asi_detected_inverted),
    .err_in                (err_in),
    .ctrl                  (ctrl),
    .h_blank               (h_blank),
    .asi_invert            (asi_invert)
  );

  srp_host_model host (
    .ref_clk     (ref_clk),
    .host_req    (host_req),
    .host_rdata  (host_rdata),
    .host_rvalid (host_rvalid)
  );

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic test_done();
    $display("comparisons %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // a hang counts as a mismatch; the run needs well under this
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 20000) begin
      err_count++;
      test_done();
    end
  end

  task automatic rd_chk(input logic [11:0] a, input logic [15:0] exp);
    logic [15:0] r;
    logic        v;
    host.read_word(a, r, v);
    check({15'h0, v}, 16'h0001);
    check(r, exp);
  endtask

  function automatic srp_ctrl_s exp_ctrl(input logic [15:0] w, input logic pin);
    return '{w[14], w[12], w[11], w[9], w[4], w[3], w[2], w[1], w[0], w[7] ? w[6] : pin};
  endfunction

  function automatic logic [15:0] exp_stat(input srp_err_s e);
    logic [9:0] b;
    b = e;
    return {5'h00, b[9:7], 1'b0, b[6:0]};
  endfunction

  function automatic logic exp_hb(input logic [15:0] w, input logic pin, input srp_timing_s t);
    logic cea;
    cea = w[7] ? w[6] : pin;
    return cea ? t.cea_hsync : (w[10] ? t.trs_h_bit : t.line_blank);
  endfunction

  function automatic logic exp_inv(input logic [15:0] w, input logic m, input logic det);
    return m & (w[13] ? ~w[14] : det);
  endfunction

  initial begin
    repeat (16) @(negedge ref_clk);
    sys_rst = 1'b0;
    for (int a = 0; a < 4; a++) rd_chk(12'(a), 16'h0000);
    host.write_word(SRP_OFS_PROC_ONE, 16'hFFFF);
    host.write_word(SRP_OFS_PROC_TWO, 16'hFFFF);
    host.write_word(SRP_OFS_RESERVED_WORD_THREE_THREE, 16'hFFFF);
    host.write_word(12'h0FF, 16'hFFFF);
    rd_chk(SRP_OFS_PROC_ONE, 16'h5EDF);
    rd_chk(SRP_OFS_PROC_TWO, 16'h6000);
    rd_chk(SRP_OFS_RESERVED_WORD_THREE_THREE, 16'h0000);
    rd_chk(12'h0FF, 16'h0000);
    rd_chk(SRP_OFS_ERR_ONE, 16'h0000);
    $display("test reserved done");
    for (int i = 0; i < 40; i++) begin
      d = (i < 4) ? corner[i] : 16'($random(seed));
      d2 = 16'($random(seed));
      timing_format_pin = 1'($random(seed));
      host.write_word(SRP_OFS_PROC_ONE, d);
      host.write_word(SRP_OFS_PROC_TWO, d2);
      rd_chk(SRP_OFS_PROC_ONE, d & 16'h5EDF);
      ec = exp_ctrl(d, timing_format_pin);
      check(16'(ctrl[9:5]), 16'(ec[9:5]));
      check(16'(ctrl[4:0]), 16'(ec[4:0]));
      repeat (8) begin
        timing_in = srp_timing_s'(3'($random(seed)));
        asi_mode = 1'($random(seed));
        asi_detected_inverted = 1'($random(seed));
        @(negedge ref_clk);
        check({14'h0, h_blank, asi_invert},
              {14'h0, exp_hb(d, timing_format_pin, timing_in),
               exp_inv(d2, asi_mode, asi_detected_inverted)});
      end
    end
    $display("test config done");
    for (int k = 0; k < 10; k++) begin
      err_in = srp_err_s'(10'h001 << k);
      @(negedge ref_clk);
      err_in = '0;
      acc = exp_stat(srp_err_s'(10'h001 << k));
      rd_chk(SRP_OFS_ERR_ONE, acc);
      rd_chk(SRP_OFS_ERR_ONE, acc);
      host.write_word(SRP_OFS_ERR_ONE, 16'hFFFF);
      rd_chk(SRP_OFS_ERR_ONE, 16'h0000);
    end
    acc = 16'h0000;
    repeat (6) begin
      err_in = srp_err_s'(10'($random(seed)));
      acc = acc | exp_stat(err_in);
      @(negedge ref_clk);
      err_in = '0;
      @(negedge ref_clk);
    end
    rd_chk(SRP_OFS_ERR_ONE, acc);
    // an event in the clearing cycle must survive the clear
    fork
      host.write_word(SRP_OFS_ERR_ONE, 16'hFFFF);
      begin
        @(negedge ref_clk);
        err_in = srp_err_s'(10'h001);
        @(negedge ref_clk);
        err_in = '0;
      end
    join
    rd_chk(SRP_OFS_ERR_ONE, 16'h0001);
    $display("test status done");
    test_done();
  end
endmodule // tb
